/* adcr_top.sv */
// converter control: apb register file, start/busy sequencer and analog routing
`timescale 1ns/1ps
// Function
// R1: left or right justify result by format bit
// R2: unused result bits read as zero
// R3: results held while converter disabled
// R4: start bit high then low starts conversion
// R5: busy set when start sequence completes
// R6: busy cleared when conversion finishes
// R7: busy bit read only, writes ignored
// R8: enable bit zero powers converter down
// R9: channel codes 0,1,3..8 select inputs
// R10: other channel codes leave input floating
// R11: source codes 0000,0100,11xx use external path
// R12: source codes select supply or amplifier fractions
// R13: source codes 10xx ground converter input
// R14: internal source disconnects external channel path
// R15: conversion clock is system clock over 2^code
// R16: analog pins lose digital function and pull-high
// R17: bandgap enable in bit 0 own register
// R18: reference select supply, pin or amplifier
// R19: two-bit amplifier gain selection
// R20: amplifier enable bit 7, input bit 4
// R21: result latched as busy clears, length parameter
// R22: result writes ignored, unused bits zero
module adcr_top
  import adcr_pkg::*;
#(
  parameter int CONV_TICKS = adcr_pkg::ADCR_CONV_TICKS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] conv_data,
  input  wire logic [8:0]  pin_analog_assign,
  output logic      [8:0]  ext_analog_input,
  output logic      [1:0]  input_path,
  output logic      [2:0]  internal_sel,
  output logic             converter_enable,
  output logic             conv_clock_tick,
  output logic             conversion_busy,
  output logic      [1:0]  reference_sel,
  output logic      [1:0]  ref_amp_gain,
  output logic             ref_amp_enable,
  output logic             ref_amp_input_sel,
  output logic             bandgap_enable,
  output logic      [8:0]  pin_digital_off,
  output logic      [8:0]  pin_pullhigh_off
);
  import adcr_pkg::*;

  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
    $error("CONV_TICKS out of range 1..255");
  end

  // ----------------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------------
  logic              start_q;
  logic              start_prev_q;
  logic              busy_q;
  logic              en_q;
  logic              justify_q;
  logic [3:0]        ch_q;
  logic [3:0]        src_q;
  logic [2:0]        div_q;
  logic [7:0]        ref_ctrl_q;
  logic              bg_en_q;
  logic [11:0]       result_q;
  adcr_state_e       state_q;
  logic [6:0]        div_cnt_q;
  logic [7:0]        tick_cnt_q;
  logic              tick_q;

  logic              setup;
  logic              wr_en;
  logic [7:0]        addr;
  logic              start_seq;
  logic              tick;
  logic              conv_done;
  logic [7:0]        res_low;
  logic [7:0]        res_high;
  logic [7:0]        rd_byte;
  logic              rd_hit;

  assign setup     = psel & ~penable;
  assign addr      = paddr[7:0];
  // unmapped addresses answer with an error and store nothing
  assign wr_en     = psel & penable & pready & pwrite & pstrb[0] & rd_hit;
  assign start_seq = start_prev_q & ~start_q & en_q; // R4

  // ----------------------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q   <= ADCR_RST_CTRL_A[ADCR_A_START];
      en_q      <= ADCR_RST_CTRL_A[ADCR_A_ENABLE];
      justify_q <= ADCR_RST_CTRL_A[ADCR_A_JUSTIFY];
      ch_q      <= ADCR_RST_CTRL_A[ADCR_A_CH_LSB +: 4];
    end else if (wr_en && addr == ADCR_OFF_CTRL_A) begin
      // busy position deliberately not stored
      start_q   <= pwdata[ADCR_A_START]; // R7
      en_q      <= pwdata[ADCR_A_ENABLE];
      justify_q <= pwdata[ADCR_A_JUSTIFY];
      ch_q      <= pwdata[ADCR_A_CH_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= ADCR_RST_CTRL_B[ADCR_B_SRC_LSB +: 4];
      div_q <= ADCR_RST_CTRL_B[ADCR_B_DIV_LSB +: 3];
    end else if (wr_en && addr == ADCR_OFF_CTRL_B) begin
      src_q <= pwdata[ADCR_B_SRC_LSB +: 4];
      div_q <= pwdata[ADCR_B_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ctrl_q <= ADCR_RST_REF;
    end else if (wr_en && addr == ADCR_OFF_REF_CTRL) begin
      ref_ctrl_q <= pwdata[7:0] & 8'h9F; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_en_q <= ADCR_RST_BANDGAP[ADCR_G_BG_EN];
    end else if (wr_en && addr == ADCR_OFF_BANDGAP) begin
      bg_en_q <= pwdata[ADCR_G_BG_EN]; // R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_q;
    end
  end

  // ----------------------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------------------
  // compare as at-or-above so a divider shrunk mid conversion cannot wrap the count
  assign tick = (div_cnt_q >= 7'((8'h01 << div_q) - 8'h01)); // R15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 7'h00;
    end else if (state_q != ADCR_ST_CONV || tick) begin
      div_cnt_q <= 7'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick & (state_q == ADCR_ST_CONV);
    end
  end

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  assign conv_done = (state_q == ADCR_ST_CONV) && tick
                     && (tick_cnt_q == 8'(CONV_TICKS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ADCR_ST_IDLE;
      busy_q     <= 1'b0;
      tick_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        ADCR_ST_IDLE: begin
          tick_cnt_q <= 8'h00;
          if (start_seq) begin
            state_q <= ADCR_ST_CONV;
            busy_q  <= 1'b1; // R5
          end
        end
        ADCR_ST_CONV: begin
          if (!en_q) begin
            // power down aborts the conversion
            state_q <= ADCR_ST_IDLE; // R8
            busy_q  <= 1'b0;
          end else if (conv_done) begin
            state_q <= ADCR_ST_IDLE;
            busy_q  <= 1'b0; // R6
          end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= ADCR_ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // result only written at completion, never by the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= ADCR_RST_RESULT;
    end else if (conv_done && en_q) begin
      result_q <= conv_data; // R21 R3 R22
    end
  end

  // ----------------------------------------------------------------------------
  // apb read path, one wait-free access phase
  // ----------------------------------------------------------------------------
  assign res_low  = justify_q ? result_q[7:0] : {result_q[3:0], 4'h0};     // R1 R2
  assign res_high = justify_q ? {4'h0, result_q[11:8]} : result_q[11:4];   // R1 R2

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (addr)
      ADCR_OFF_RES_LOW:  rd_byte = res_low;
      ADCR_OFF_RES_HIGH: rd_byte = res_high;
      ADCR_OFF_CTRL_A:   rd_byte = {start_q, busy_q, en_q, justify_q, ch_q};
      ADCR_OFF_CTRL_B:   rd_byte = {src_q, 1'b0, div_q}; // R22
      ADCR_OFF_REF_CTRL: rd_byte = ref_ctrl_q;
      ADCR_OFF_BANDGAP:  rd_byte = {7'h00, bg_en_q};
      default:           rd_hit  = 1'b0;
    endcase
    if (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
      prdata  <= (setup && !pwrite && rd_hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------------------
  adcr_path_e path_d;
  logic [2:0] int_d;

  always_comb begin
    path_d = ADCR_PATH_EXT; // R11
    int_d  = 3'b000;
    case (src_q)
      4'h1, 4'h2, 4'h3: begin
        path_d = ADCR_PATH_INT; // R12
        int_d  = {1'b0, src_q[1:0]};
      end
      4'h5, 4'h6, 4'h7: begin
        path_d = ADCR_PATH_INT; // R12
        int_d  = {1'b1, src_q[1:0]};
      end
      4'h8, 4'h9, 4'hA, 4'hB: path_d = ADCR_PATH_GND; // R13
      default: path_d = ADCR_PATH_EXT;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < ADCR_CHANNELS; gi++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_analog_input[gi] <= 1'b0;
        end else begin
          ext_analog_input[gi] <= (path_d == ADCR_PATH_EXT) // R14
                                  && (ch_q == 4'(gi)) && (ch_q != ADCR_CH_HOLE); // R9 R10
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_path        <= ADCR_PATH_EXT;
      internal_sel      <= 3'b000;
      converter_enable  <= 1'b0;
      conv_clock_tick   <= 1'b0;
      conversion_busy   <= 1'b0;
      reference_sel     <= 2'b00;
      ref_amp_gain      <= 2'b00;
      ref_amp_enable    <= 1'b0;
      ref_amp_input_sel <= 1'b0;
      bandgap_enable    <= 1'b0;
      pin_digital_off   <= 9'h000;
      pin_pullhigh_off  <= 9'h000;
    end else begin
      input_path        <= path_d;
      internal_sel      <= int_d;
      converter_enable  <= en_q; // R8
      conv_clock_tick   <= tick_q;
      conversion_busy   <= busy_q;
      reference_sel     <= ref_ctrl_q[ADCR_R_REF_LSB +: 2]; // R18
      ref_amp_gain      <= ref_ctrl_q[ADCR_R_GAIN_LSB +: 2]; // R19
      ref_amp_enable    <= ref_ctrl_q[ADCR_R_AMP_EN]; // R20
      ref_amp_input_sel <= ref_ctrl_q[ADCR_R_AMP_IN]; // R20
      bandgap_enable    <= bg_en_q; // R17
      pin_digital_off   <= pin_analog_assign; // R16
      pin_pullhigh_off  <= pin_analog_assign; // R16
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  sequence s_start_seq;
    start_prev_q && !start_q && en_q && state_q == ADCR_ST_IDLE;
  endsequence

  sequence s_done;
    conv_done && en_q;
  endsequence

  busy_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    s_start_seq |=> busy_q ##1 conversion_busy)
    else $error("busy not raised after start sequence");

  busy_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    s_done |=> !busy_q && state_q == ADCR_ST_IDLE)
    else $error("busy not cleared at completion");

  result_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
    s_done |=> result_q == $past(conv_data))
    else $error("result not latched when busy clears");

  result_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    !en_q |=> $stable(result_q))
    else $error("result changed while disabled");

  busy_ro_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (wr_en && addr == ADCR_OFF_CTRL_A && state_q == ADCR_ST_IDLE && !start_seq)
      |=> !busy_q)
    else $error("busy written by software");

  justify_left_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (setup && !pwrite && addr == ADCR_OFF_RES_HIGH && !justify_q)
      |=> prdata[7:0] == $past(result_q[11:4]))
    else $error("left justified high byte wrong");

  justify_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (setup && !pwrite && addr == ADCR_OFF_RES_LOW && !justify_q)
      |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h00_0000)
    else $error("unused result bits not zero");

  hole_float_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (ch_q == ADCR_CH_HOLE || ch_q > 4'h8) |=> ext_analog_input == 9'h000)
    else $error("undefined channel code connects an input");

  internal_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (path_d != ADCR_PATH_EXT) |=> ext_analog_input == 9'h000 && input_path != ADCR_PATH_EXT)
    else $error("external path left on with internal source");

  ground_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (src_q[3:2] == 2'b10) |=> input_path == ADCR_PATH_GND)
    else $error("ground not selected");

  undivided_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (state_q == ADCR_ST_CONV && div_q == 3'h0 && en_q) |-> tick)
    else $error("undivided conversion clock missing tick");

  power_down_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (!en_q && state_q == ADCR_ST_CONV) |=> !busy_q ##1 !converter_enable)
    else $error("disabled converter still running");

endmodule

/* adcr_pkg.sv */
// register map, field positions and reset values of the converter control block
package adcr_pkg;

  // ----------------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADCR_OFF_RES_LOW   = 8'h00;
  localparam logic [7:0] ADCR_OFF_RES_HIGH  = 8'h04;
  localparam logic [7:0] ADCR_OFF_CTRL_A    = 8'h08;
  localparam logic [7:0] ADCR_OFF_CTRL_B    = 8'h0C;
  localparam logic [7:0] ADCR_OFF_REF_CTRL  = 8'h10;
  localparam logic [7:0] ADCR_OFF_BANDGAP   = 8'h14;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int ADCR_A_START   = 7;
  localparam int ADCR_A_BUSY    = 6;
  localparam int ADCR_A_ENABLE  = 5;
  localparam int ADCR_A_JUSTIFY = 4;
  localparam int ADCR_A_CH_LSB  = 0;
  localparam int ADCR_B_SRC_LSB = 4;
  localparam int ADCR_B_DIV_LSB = 0;
  localparam int ADCR_R_AMP_EN  = 7;
  localparam int ADCR_R_AMP_IN  = 4;
  localparam int ADCR_R_REF_LSB = 2;
  localparam int ADCR_R_GAIN_LSB = 0;
  localparam int ADCR_G_BG_EN   = 0;

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  ADCR_RST_CTRL_A  = 8'h00;
  localparam logic [7:0]  ADCR_RST_CTRL_B  = 8'h00;
  localparam logic [7:0]  ADCR_RST_REF     = 8'h00;
  localparam logic [7:0]  ADCR_RST_BANDGAP = 8'h00;
  localparam logic [11:0] ADCR_RST_RESULT  = 12'h000;

  // ----------------------------------------------------------------------------
  // codes and counts
  // ----------------------------------------------------------------------------
  localparam int ADCR_CHANNELS     = 9;
  localparam logic [3:0] ADCR_CH_HOLE  = 4'h2;
  localparam int ADCR_CONV_TICKS   = 16;
  localparam int ADCR_DIV_MAX_LOG2 = 7;

  typedef enum logic [1:0] {
    ADCR_ST_IDLE = 2'b01,
    ADCR_ST_CONV = 2'b10
  } adcr_state_e;

  typedef enum logic [1:0] {
    ADCR_PATH_EXT   = 2'b00,
    ADCR_PATH_INT   = 2'b01,
    ADCR_PATH_GND   = 2'b10
  } adcr_path_e;

endpackage

/* adcr_tb.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module testbench;
  import adcr_pkg::*;

  localparam int TICKS = 4;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [11:0] conv_data;
  logic [8:0]  pin_analog_assign, ext_analog_input, pin_digital_off, pin_pullhigh_off;
  logic [1:0]  input_path, reference_sel, ref_amp_gain;
  logic [2:0]  internal_sel;
  logic        converter_enable, conv_clock_tick, conversion_busy;
  logic        ref_amp_enable, ref_amp_input_sel, bandgap_enable;
  int          n_mismatch, tests_run;
  int          cycles = 0;

  adcr_top #(.CONV_TICKS(TICKS)) adcr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_data(conv_data), .pin_analog_assign(pin_analog_assign),
    .ext_analog_input(ext_analog_input), .input_path(input_path),
    .internal_sel(internal_sel), .converter_enable(converter_enable),
    .conv_clock_tick(conv_clock_tick), .conversion_busy(conversion_busy),
    .reference_sel(reference_sel), .ref_amp_gain(ref_amp_gain),
    .ref_amp_enable(ref_amp_enable), .ref_amp_input_sel(ref_amp_input_sel),
    .bandgap_enable(bandgap_enable), .pin_digital_off(pin_digital_off),
    .pin_pullhigh_off(pin_pullhigh_off));

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic end_of_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h0000_0001, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, {24'h00_0000, e}, rd);
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (conversion_busy !== v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("conversion_busy", {31'h0, v}, {31'h0, conversion_busy});
  endtask

  // start bit high then low, other control bits kept
  task automatic start(input logic [7:0] a);
    wr(ADCR_OFF_CTRL_A, a | 8'h80);
    wr(ADCR_OFF_CTRL_A, a);
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    rdchk("ctrl_a", ADCR_OFF_CTRL_A, ADCR_RST_CTRL_A);
    rdchk("ctrl_b", ADCR_OFF_CTRL_B, ADCR_RST_CTRL_B);
    rdchk("ref_ctrl", ADCR_OFF_REF_CTRL, ADCR_RST_REF);
    rdchk("bandgap_ctrl", ADCR_OFF_BANDGAP, ADCR_RST_BANDGAP);
    rdchk("res_low", ADCR_OFF_RES_LOW, 8'h00);
    rdchk("res_high", ADCR_OFF_RES_HIGH, 8'h00);
    xfer(1'b0, 8'h18, 8'h00);
    chk("pslverr", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
  endtask

  task automatic t_access;
    wr(ADCR_OFF_CTRL_B, 8'hFF);
    rdchk("ctrl_b", ADCR_OFF_CTRL_B, 8'hF7);
    wr(ADCR_OFF_CTRL_A, 8'h40);
    rdchk("ctrl_a busy", ADCR_OFF_CTRL_A, 8'h00);
    wr(ADCR_OFF_RES_HIGH, 8'hFF);
    rdchk("res_high", ADCR_OFF_RES_HIGH, 8'h00);
    wr(ADCR_OFF_REF_CTRL, 8'hFF);
    rdchk("ref_ctrl", ADCR_OFF_REF_CTRL, 8'h9F);
    wr(ADCR_OFF_BANDGAP, 8'hFF);
    rdchk("bandgap_ctrl", ADCR_OFF_BANDGAP, 8'h01);
    repeat (2) @(posedge pclk);
    chk("ref_sel", 32'h0000_0003, {30'h0, reference_sel});
    chk("amp_gain", 32'h0000_0003, {30'h0, ref_amp_gain});
    chk("amp_en", 32'h0000_0001, {31'h0, ref_amp_enable});
    chk("amp_in", 32'h0000_0001, {31'h0, ref_amp_input_sel});
    chk("bg_en", 32'h0000_0001, {31'h0, bandgap_enable});
    wr(ADCR_OFF_REF_CTRL, 8'h06);
    wr(ADCR_OFF_BANDGAP, 8'h00);
    repeat (2) @(posedge pclk);
    chk("ref_sel", 32'h0000_0001, {30'h0, reference_sel});
    chk("amp_gain", 32'h0000_0002, {30'h0, ref_amp_gain});
    chk("amp_en", 32'h0000_0000, {31'h0, ref_amp_enable});
    chk("amp_in", 32'h0000_0000, {31'h0, ref_amp_input_sel});
    chk("bg_en", 32'h0000_0000, {31'h0, bandgap_enable});
  endtask

  task automatic t_conv;
    conv_data <= 12'hB7D;
    wr(ADCR_OFF_CTRL_B, 8'h03);
    wr(ADCR_OFF_CTRL_A, 8'hA0);
    repeat (4) @(posedge pclk);
    rdchk("ctrl_a start high", ADCR_OFF_CTRL_A, 8'hA0);
    chk("converter_enable", 32'h0000_0001, {31'h0, converter_enable});
    wr(ADCR_OFF_CTRL_A, 8'h20);
    repeat (3) @(posedge pclk);
    rdchk("ctrl_a busy", ADCR_OFF_CTRL_A, 8'h60);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdchk("res_high left", ADCR_OFF_RES_HIGH, 8'hB7);
    rdchk("res_low left", ADCR_OFF_RES_LOW, 8'hD0);
    wr(ADCR_OFF_CTRL_A, 8'h30);
    rdchk("res_high right", ADCR_OFF_RES_HIGH, 8'h0B);
    rdchk("res_low right", ADCR_OFF_RES_LOW, 8'h7D);
  endtask

  task automatic t_hold;
    conv_data <= 12'h123;
    wr(ADCR_OFF_CTRL_A, 8'h10);
    repeat (2) @(posedge pclk);
    chk("converter_enable", 32'h0000_0000, {31'h0, converter_enable});
    start(8'h10);
    repeat (3) @(posedge pclk);
    rdchk("ctrl_a off", ADCR_OFF_CTRL_A, 8'h10);
    rdchk("res_low off", ADCR_OFF_RES_LOW, 8'h7D);
    wr(ADCR_OFF_CTRL_B, 8'h07);
    start(8'h30);
    repeat (3) @(posedge pclk);
    wr(ADCR_OFF_CTRL_A, 8'h10);
    repeat (3) @(posedge pclk);
    rdchk("ctrl_a abort", ADCR_OFF_CTRL_A, 8'h10);
    rdchk("res_high abort", ADCR_OFF_RES_HIGH, 8'h0B);
    rdchk("res_low abort", ADCR_OFF_RES_LOW, 8'h7D);
  endtask

  task automatic t_div;
    int n;
    for (int d = 0; d < 8; d++) begin
      wr(ADCR_OFF_CTRL_B, 8'(d));
      start(8'h20);
      n = 0;
      while (conv_clock_tick !== 1'b1 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (conv_clock_tick !== 1'b1 && n < 300);
      chk("tick spacing", 32'(1 << d), 32'(n));
      wait_busy(1'b0);
    end
  endtask

  task automatic t_route;
    logic ext, gnd;
    logic [3:0] sv;
    for (int s = 0; s < 16; s++) begin
      sv = 4'(s);
      ext = (s == 0 || s == 4 || s >= 12);
      gnd = (sv[3:2] == 2'b10);
      wr(ADCR_OFF_CTRL_B, {sv, 4'h0});
      for (int c = 0; c < 16; c++) begin
        wr(ADCR_OFF_CTRL_A, 8'(c));
        repeat (2) @(posedge pclk);
        chk("input_path", ext ? 32'h0 : (gnd ? 32'h2 : 32'h1), {30'h0, input_path});
        if (!gnd) chk("ext_in", (ext && c <= 8 && c != 2) ? 32'(1 << c) : 32'h0,
                      {23'h0, ext_analog_input});
        if (!ext && !gnd) chk("internal_sel", {29'h0, sv[2:0]}, {29'h0, internal_sel});
      end
    end
  endtask

  task automatic t_pins;
    pin_analog_assign <= 9'h155;
    repeat (3) @(posedge pclk);
    chk("digital_off", 32'h0000_0155, {23'h0, pin_digital_off});
    chk("pullhigh_off", 32'h0000_0155, {23'h0, pin_pullhigh_off});
    pin_analog_assign <= 9'h0AA;
    repeat (3) @(posedge pclk);
    chk("digital_off", 32'h0000_00AA, {23'h0, pin_digital_off});
    chk("pullhigh_off", 32'h0000_00AA, {23'h0, pin_pullhigh_off});
  endtask

  // ----------------------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    conv_data = 12'h000;
    pin_analog_assign = 9'h000;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_access();
    t_conv();
    t_hold();
    t_div();
    t_route();
    t_pins();
    end_of_test();
  end
endmodule
